// ---- inc/gpio_path_defines.svh ----
// constants for the dual-edge gpio data path
//
// Contract
// - bypass mode is a plain wire both ways
// - single-register mode: one register per pin, direction
// - receive word: two bits per pin in DDR
// - transmit word: two bits per pin in DDR
// - output buffer driven only while drive enable high; output mode without the enable port drives always
// - sleep port low enables the input buffer
// - async clear forces register outputs to zero now
// - async preset forces register outputs to one now
// - sync clear loads zero on next active edge
// - capture enable gates input register updates; the code honours it in DDR mode only
// - launch enable gates output register updates; the code honours it in DDR mode only
// - without enable ports registers update every edge
// - DDR output inversion inverts data toward pad
// - inverted capture clock takes first bit falling
// - dual-edge OE adds half-cycle high impedance
// - single-register OE passes one register first
// - DDR power-up level follows power-up-high option only when no clear or preset port is used
// - bus-hold keeps pin at last driven level
// - open drain only pulls low or releases
// - drive enable always present in bidirectional mode
// - preset only for DDR output, power-up-high off
// - negative pad only with differential buffer enabled
// - DDR input: rise, fall, then realign on fall
// - DDR output: first bit rising, second falling
// - all cells share one clear and preset
`ifndef GPIO_PATH_DEFINES_SVH
`define GPIO_PATH_DEFINES_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define GPIO_DDR_BITS 2
`define GPIO_SDR_BITS 1
`define GPIO_FIRST_BIT 0
`define GPIO_SECOND_BIT 1
`define GPIO_WIDTH_MIN 1
`define GPIO_WIDTH_MAX 128

// ----------------------------------------
// reset levels
// ----------------------------------------
`define GPIO_LEVEL_LOW 1'h0
`define GPIO_LEVEL_HIGH 1'h1

`endif

// ---- inc/gpio_path_pkg.sv ----
// types shared by the dual-edge gpio data path
package gpio_path_pkg;
    typedef enum logic [2:0] {
        DIR_IN = 3'h1,
        DIR_OUT = 3'h2,
        DIR_BIDIR = 3'h4
    } dir_t;
    typedef enum logic [2:0] {
        MODE_BYPASS = 3'h1,
        MODE_SDR = 3'h2,
        MODE_DDR = 3'h4
    } reg_mode_t;
endpackage

// ---- design/ddr_gpio_data_path.sv ----
// dual-edge gpio data path between pads and core logic
`timescale 1ns/1ps
`include "gpio_path_defines.svh"

module ddr_gpio_data_path #(
    parameter int WIDTH = 1,
    parameter gpio_path_pkg::dir_t DIRECTION = gpio_path_pkg::DIR_BIDIR,
    parameter gpio_path_pkg::reg_mode_t REG_MODE = gpio_path_pkg::MODE_DDR,
    parameter bit USE_OE_PORT = 1'b0,
    parameter bit USE_SLEEP_PORT = 1'b0,
    parameter bit USE_ACLR_PORT = 1'b0,
    parameter bit USE_ASET_PORT = 1'b0,
    parameter bit USE_SCLR_PORT = 1'b0,
    parameter bit POWER_UP_HIGH = 1'b0,
    parameter bit USE_CLKEN_PORTS = 1'b0,
    parameter bit INVERT_DOUT = 1'b0,
    parameter bit INVERT_INCLK = 1'b0,
    parameter bit OE_SINGLE_REG = 1'b0,
    parameter bit OE_DUAL_EDGE = 1'b0,
    parameter bit USE_BUS_HOLD = 1'b0,
    parameter bit USE_OPEN_DRAIN = 1'b0,
    parameter bit USE_DIFF = 1'b0,
    localparam int WORD = (REG_MODE == gpio_path_pkg::MODE_DDR) ?
        `GPIO_DDR_BITS * WIDTH : `GPIO_SDR_BITS * WIDTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // capture and launch clocks, sampled levels
    input wire logic inClock,
    input wire logic inClockEn,
    input wire logic outClock,
    input wire logic outClockEn,
    // register clears and preset
    input wire logic asyncClear,
    input wire logic asyncPreset,
    input wire logic syncClear,
    // core side
    input wire logic [WORD-1:0] txWord,
    input wire logic driveEnable,
    input wire logic sleepN,
    output logic [WORD-1:0] rxWord,
    // pad side
    input wire logic [WIDTH-1:0] padIn,
    input wire logic [WIDTH-1:0] padInN,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOutN,
    output logic [WIDTH-1:0] padOe,
    output logic [WIDTH-1:0] holdEn,
    output logic [WIDTH-1:0] holdLevel
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (WIDTH < `GPIO_WIDTH_MIN || WIDTH > `GPIO_WIDTH_MAX) begin : g_bad_width
        $error("width out of range");
    end
    if (OE_SINGLE_REG && OE_DUAL_EDGE) begin : g_bad_oe
        $error("choose one output-enable register style");
    end

    localparam bit IS_BYP = (REG_MODE == gpio_path_pkg::MODE_BYPASS);
    localparam bit IS_DDR = (REG_MODE == gpio_path_pkg::MODE_DDR);
    localparam bit HAS_IN = (DIRECTION != gpio_path_pkg::DIR_OUT);
    localparam bit HAS_OUT = (DIRECTION != gpio_path_pkg::DIR_IN);
    localparam bit ACLR_ON = USE_ACLR_PORT && IS_DDR;
    localparam bit ASET_ON = USE_ASET_PORT && IS_DDR && HAS_OUT && !POWER_UP_HIGH;
    localparam bit INIT_HIGH = IS_DDR && POWER_UP_HIGH &&
        !USE_ACLR_PORT && !USE_ASET_PORT && !USE_SCLR_PORT;
    localparam bit INV_TX = INVERT_DOUT && IS_DDR && (DIRECTION == gpio_path_pkg::DIR_OUT);
    localparam logic [WIDTH-1:0] DATA_INIT =
        INIT_HIGH ? {WIDTH{`GPIO_LEVEL_HIGH}} : {WIDTH{`GPIO_LEVEL_LOW}};

    // refuse options the logic would otherwise ignore without a word
    if (OE_DUAL_EDGE && !(IS_DDR && HAS_OUT)) begin : g_bad_oe_dual
        $error("dual-edge output enable needs a ddr output path");
    end
    if (OE_SINGLE_REG && (IS_BYP || !HAS_OUT)) begin : g_bad_oe_single
        $error("registered output enable needs a registered output path");
    end
    if (USE_ASET_PORT && !ASET_ON) begin : g_bad_aset
        $error("preset port not available with these options");
    end
    if (USE_ACLR_PORT && !IS_DDR) begin : g_bad_aclr
        $error("clear port needs ddr mode");
    end
    if (USE_SLEEP_PORT && !HAS_IN) begin : g_bad_sleep
        $error("sleep port needs an input path");
    end
    if (INVERT_INCLK && !(IS_DDR && HAS_IN)) begin : g_bad_inclk
        $error("capture clock inversion needs a ddr input path");
    end
    if (INVERT_DOUT && !INV_TX) begin : g_bad_dout
        $error("data inversion needs a ddr output-only path");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic inPrev;
        logic outPrev;
        logic [WIDTH-1:0] riseCapture;
        logic [WIDTH-1:0] fallCapture;
        logic [WIDTH-1:0] realign;
        logic [WIDTH-1:0] firstLaunch;
        logic [WIDTH-1:0] secondLaunch;
        logic [WIDTH-1:0] padData;
        logic oeFirst;
        logic oeSecond;
        logic [WIDTH-1:0] lastLevel;
    } state_t;

    localparam state_t RESET_STATE = '{
        inPrev: `GPIO_LEVEL_LOW,
        outPrev: `GPIO_LEVEL_LOW,
        riseCapture: DATA_INIT,
        fallCapture: DATA_INIT,
        realign: DATA_INIT,
        firstLaunch: DATA_INIT,
        secondLaunch: DATA_INIT,
        padData: DATA_INIT,
        oeFirst: `GPIO_LEVEL_LOW,
        oeSecond: `GPIO_LEVEL_LOW,
        lastLevel: {WIDTH{`GPIO_LEVEL_LOW}}
    };

    state_t s;
    state_t next_s;

    // ----------------------------------------
    // effective controls
    // ----------------------------------------
    logic clrNow;
    logic setNow;
    logic sclrNow;
    logic inEn;
    logic outEn;
    logic oeIn;
    logic bufOn;
    logic inEdge;
    logic inRise;
    logic inFall;
    logic outRise;
    logic outFall;
    logic drive;
    logic [WIDTH-1:0] padSeen;
    logic [WIDTH-1:0] txFirst;
    logic [WIDTH-1:0] txSecond;
    logic [WIDTH-1:0] padData;
    logic [WIDTH-1:0] rxFirst;
    logic [WIDTH-1:0] rxSecond;

    // one shared clear and preset for every cell
    assign clrNow = ACLR_ON && asyncClear;
    assign setNow = ASET_ON && asyncPreset && !clrNow;
    assign sclrNow = USE_SCLR_PORT && !IS_BYP && syncClear;
    // enables only exist in ddr mode; elsewhere every edge counts
    assign inEn = !(USE_CLKEN_PORTS && IS_DDR) || inClockEn;
    assign outEn = !(USE_CLKEN_PORTS && IS_DDR) || outClockEn;
    // output mode without the port drives permanently
    assign oeIn = (DIRECTION == gpio_path_pkg::DIR_BIDIR || USE_OE_PORT) ?
        driveEnable : `GPIO_LEVEL_HIGH;
    assign bufOn = !USE_SLEEP_PORT || !sleepN;
    assign padSeen = padIn & {WIDTH{bufOn}};
    assign inEdge = (INVERT_INCLK && IS_DDR) ? !inClock : inClock;
    assign inRise = inEdge && !s.inPrev;
    assign inFall = !inEdge && s.inPrev;
    assign outRise = outClock && !s.outPrev;
    assign outFall = !outClock && s.outPrev;

    // ----------------------------------------
    // word layout, first edge in bit zero
    // ----------------------------------------
    always_comb begin
        txFirst = '0;
        txSecond = '0;
        rxWord = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (IS_DDR) begin
                txFirst[i] = txWord[`GPIO_DDR_BITS*i+`GPIO_FIRST_BIT];
                txSecond[i] = txWord[`GPIO_DDR_BITS*i+`GPIO_SECOND_BIT];
                rxWord[`GPIO_DDR_BITS*i+`GPIO_FIRST_BIT] = rxFirst[i];
                rxWord[`GPIO_DDR_BITS*i+`GPIO_SECOND_BIT] = rxSecond[i];
            end else begin
                txFirst[i] = txWord[i];
                rxWord[i] = rxFirst[i];
            end
        end
    end

    // ----------------------------------------
    // receive outputs
    // ----------------------------------------
    always_comb begin
        if (IS_BYP) begin
            rxFirst = padSeen;
            rxSecond = '0;
        end else if (clrNow) begin
            rxFirst = '0;
            rxSecond = '0;
        end else if (setNow) begin
            rxFirst = '1;
            rxSecond = '1;
        end else if (IS_DDR) begin
            rxFirst = s.realign;
            rxSecond = s.fallCapture;
        end else begin
            rxFirst = s.riseCapture;
            rxSecond = '0;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.inPrev = inEdge;
        next_s.outPrev = outClock;
        // input cell: realign takes the old rise value on the fall
        if (inRise && inEn) begin
            next_s.riseCapture = sclrNow ? '0 : padSeen;
        end
        if (inFall && inEn && IS_DDR) begin
            next_s.fallCapture = sclrNow ? '0 : padSeen;
            next_s.realign = sclrNow ? '0 : s.riseCapture;
        end
        // output cell: second bit follows its input while clock low
        if (outRise && outEn) begin
            next_s.firstLaunch = sclrNow ? '0 : (txFirst ^ {WIDTH{INV_TX}});
            next_s.padData = next_s.firstLaunch;
            next_s.oeFirst = sclrNow ? `GPIO_LEVEL_LOW : oeIn;
        end
        if (!outClock && outEn && IS_DDR) begin
            next_s.secondLaunch = sclrNow ? '0 : (txSecond ^ {WIDTH{INV_TX}});
        end
        if (outFall && outEn && IS_DDR) begin
            next_s.padData = next_s.secondLaunch;
            next_s.oeSecond = sclrNow ? `GPIO_LEVEL_LOW : s.oeFirst;
        end
        // held levels follow the forced outputs
        if (clrNow || setNow) begin
            next_s.riseCapture = {WIDTH{setNow}};
            next_s.fallCapture = {WIDTH{setNow}};
            next_s.realign = {WIDTH{setNow}};
            next_s.firstLaunch = {WIDTH{setNow}};
            next_s.secondLaunch = {WIDTH{setNow}};
            next_s.padData = {WIDTH{setNow}};
        end
        for (int i = 0; i < WIDTH; i++) begin
            next_s.lastLevel[i] = padOe[i] ? padOut[i] : padSeen[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // pad side
    // ----------------------------------------
    always_comb begin
        if (!HAS_OUT) begin
            drive = `GPIO_LEVEL_LOW;
        end else if (IS_DDR && OE_DUAL_EDGE) begin
            // needs both halves, so the rise is delayed half a cycle
            drive = s.oeFirst && s.oeSecond && !clrNow;
        end else if (!IS_BYP && OE_SINGLE_REG) begin
            drive = s.oeFirst && !clrNow;
        end else begin
            drive = oeIn;
        end
    end

    always_comb begin
        if (IS_BYP) begin
            padData = txFirst;
        end else if (clrNow) begin
            padData = '0;
        end else if (setNow) begin
            padData = '1;
        end else begin
            padData = s.padData;
        end
    end

    always_comb begin
        if (USE_OPEN_DRAIN) begin
            // a one releases the line so others may pull it low
            padOut = '0;
            padOe = {WIDTH{drive}} & ~padData;
        end else begin
            padOut = padData;
            padOe = {WIDTH{drive}};
        end
        padOutN = (USE_DIFF && HAS_OUT) ? ~padOut : '0;
        holdEn = USE_BUS_HOLD ? ~padOe : '0;
        holdLevel = USE_BUS_HOLD ? s.lastLevel : '0;
    end

endmodule // ddr_gpio_data_path

// ---- testbench/gpio_path_props.sv ----
// assertion checker for the dual-edge gpio data path
`timescale 1ns/1ps
module gpio_path_props #(
    parameter int WIDTH = 1,
    parameter int WORD = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // clocks and controls
    input wire logic inClock,
    input wire logic inClockEn,
    input wire logic outClock,
    input wire logic outClockEn,
    input wire logic asyncClear,
    input wire logic asyncPreset,
    input wire logic syncClear,
    input wire logic driveEnable,
    // outputs
    input wire logic [WORD-1:0] rxWord,
    input wire logic [WIDTH-1:0] padOut,
    input wire logic [WIDTH-1:0] padOutN,
    input wire logic [WIDTH-1:0] padOe,
    input wire logic [WIDTH-1:0] holdEn,
    input wire logic [WIDTH-1:0] holdLevel
);
    typedef struct packed {
        logic inPrev;
        logic outPrev;
        logic [3:0] sinceIn;
        logic [3:0] sinceOut;
    } watch_t;
    watch_t st;
    watch_t next_st;
    // cycles since the last enabled clock toggle, saturating
    always_comb begin
        next_st = st;
        next_st.inPrev = inClock;
        next_st.outPrev = outClock;
        if (st.sinceIn != 4'hf) next_st.sinceIn = st.sinceIn + 4'h1;
        if (st.sinceOut != 4'hf) next_st.sinceOut = st.sinceOut + 4'h1;
        if (inClock != st.inPrev && inClockEn) next_st.sinceIn = 4'h0;
        if (outClock != st.outPrev && outClockEn) next_st.sinceOut = 4'h0;
        if (srst) next_st = '0;
    end
    always_ff @(posedge sys_clk) st <= next_st;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_drive_on;
        (driveEnable && outClockEn && !syncClear)[*8];
    endsequence
    sequence s_drive_off;
        (!driveEnable && outClockEn)[*8];
    endsequence
    sequence s_clear;
        (syncClear && inClockEn && outClockEn)[*8];
    endsequence

    aclr_rx_a: assert property (asyncClear |-> rxWord == '0)
        else $error("receive word not forced low");
    aclr_pad_a: assert property (asyncClear |-> padOut == '0)
        else $error("pad data not forced low");
    sclr_load_a: assert property (s_clear |-> ##1 (rxWord == '0 && padOut == '0))
        else $error("sync clear did not load zero");
    drive_on_a: assert property (s_drive_on |-> padOe == '1)
        else $error("pad not driven");
    drive_off_a: assert property (s_drive_off |-> padOe == '0)
        else $error("pad driven without enable");
    rx_gate_a: assert property ($changed(rxWord) |-> st.sinceIn <= 4'h5 || asyncClear
        || $past(asyncClear) || asyncPreset || $past(asyncPreset) || $past(srst))
        else $error("receive word moved without event");
    pad_gate_a: assert property ($changed(padOut) |-> st.sinceOut <= 4'h5 || asyncClear
        || $past(asyncClear) || asyncPreset || $past(asyncPreset) || $past(srst))
        else $error("pad data moved without event");
    neg_pad_a: assert property (padOutN == '0)
        else $error("negative pad active");
    no_hold_a: assert property (holdEn == '0 && holdLevel == '0)
        else $error("bus hold active");
endmodule // gpio_path_props

bind ddr_gpio_data_path gpio_path_props #(.WIDTH(WIDTH), .WORD(WORD)) props_i (
    .sys_clk(sys_clk), .srst(srst), .inClock(inClock), .inClockEn(inClockEn),
    .outClock(outClock), .outClockEn(outClockEn), .asyncClear(asyncClear),
    .asyncPreset(asyncPreset), .syncClear(syncClear), .driveEnable(driveEnable),
    .rxWord(rxWord), .padOut(padOut), .padOutN(padOutN), .padOe(padOe), .holdEn(holdEn),
    .holdLevel(holdLevel));

// ---- testbench/pad_model.sv ----
// pad and off-chip driver model for one pin
`timescale 1ns/1ps
module pad_model (
    // clock
    input wire logic sys_clk,
    // device side
    input wire logic padOut,
    input wire logic padOe,
    // off-chip driver
    input wire logic extEn,
    input wire logic extVal,
    output logic padIn
);
    logic last;
    always_ff @(posedge sys_clk) last <= padIn;
    // an undriven wire shows the inverse of its last level, never a stale copy
    always_comb begin
        if (padOe) padIn = padOut;
        else if (extEn) padIn = extVal;
        else padIn = ~last;
    end
endmodule // pad_model

// ---- testbench/testbench.sv ----
// self-checking bench for the dual-edge gpio data path
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic ioClk = 1'b0;
    logic clkEn = 1'b1;
    logic asyncClear = 1'b0;
    logic asyncPreset = 1'b0;
    logic syncClear = 1'b0;
    logic [1:0] txWord = 2'h0;
    logic driveEnable = 1'b0;
    logic extEn = 1'b1;
    logic extVal = 1'b0;
    logic [1:0] rxWord;
    logic padIn, padOut, padOe;
    logic padOutN, holdEn, holdLevel;
    logic [31:0] seed = 32'h052f;
    logic [1:0] lastRx = 2'h0;
    logic [1:0] lastPad = 2'h0;
    logic [1:0] expRx[$];
    logic [1:0] expPad[$];
    event rxEv;
    event padEv;
    int error_cnt = 0;
    int num_checks = 0;

    always #25 sys_clk = ~sys_clk;

    ddr_gpio_data_path #(.USE_ACLR_PORT(1'b1), .USE_ASET_PORT(1'b1), .USE_SCLR_PORT(1'b1),
        .USE_CLKEN_PORTS(1'b1), .OE_SINGLE_REG(1'b1)) DUT (.sys_clk(sys_clk), .srst(srst),
        .inClock(ioClk), .inClockEn(clkEn), .outClock(ioClk), .outClockEn(clkEn),
        .asyncClear(asyncClear), .asyncPreset(asyncPreset), .syncClear(syncClear),
        .txWord(txWord), .driveEnable(driveEnable), .sleepN(1'b0), .rxWord(rxWord),
        .padIn(padIn), .padInN(1'b0), .padOut(padOut), .padOutN(padOutN), .padOe(padOe),
        .holdEn(holdEn), .holdLevel(holdLevel));
    pad_model PAD (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe), .extEn(extEn),
        .extVal(extVal), .padIn(padIn));

    // ----------------------------------------
    // scoreboard
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally(input string name, input logic [1:0] exp, input logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_rx(input logic [1:0] got);
        tally("rxWord", expRx.pop_front(), got);
    endtask
    task automatic cmp_pad(input logic [1:0] got);
        tally("padOe padOut", expPad.pop_front(), got);
    endtask
    always @(rxEv) cmp_rx(rxWord);
    always @(padEv) cmp_pad({padOe, padOut});
    always @(padEv) tally("padOutN holdEn", 2'h0, {padOutN, holdEn | holdLevel});
    task automatic note_rx(input logic [1:0] v);
        expRx.push_back(v);
        ->rxEv;
    endtask
    task automatic note_pad(input logic [1:0] v);
        expPad.push_back(v);
        ->padEv;
    endtask

    // ----------------------------------------
    // one launch and capture period, five cycles a phase
    // ----------------------------------------
    task automatic period(input logic [1:0] pin, input logic [1:0] tx, input logic oe,
        input logic hold, input logic clr, input logic chkRx);
        logic [1:0] eh;
        logic [1:0] el;
        logic [1:0] er;
        eh = hold ? lastPad : (clr ? 2'h0 : {oe, tx[0]});
        el = hold ? lastPad : (clr ? 2'h0 : {oe, tx[1]});
        er = hold ? lastRx : (clr ? 2'h0 : pin);
        ioClk <= 1'b1;
        extVal <= pin[0];
        txWord <= tx;
        driveEnable <= oe;
        extEn <= ~oe;
        repeat (4) @(posedge sys_clk);
        #1 note_pad(eh);
        @(posedge sys_clk);
        ioClk <= 1'b0;
        extVal <= pin[1];
        repeat (4) @(posedge sys_clk);
        #1 note_pad(el);
        if (chkRx) note_rx(er);
        lastPad = el;
        if (chkRx) lastRx = er;
        @(posedge sys_clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            period(seed[5:4], seed[3:2], 1'b0, 1'b0, 1'b0, 1'b1);
        end
        $display("capture test ended");
        clkEn <= 1'b0;
        period(~lastRx, ~lastPad, 1'b0, 1'b1, 1'b0, 1'b1);
        clkEn <= 1'b1;
        $display("enable test ended");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            period(seed[5:4], seed[3:2], 1'b1, 1'b0, 1'b0, 1'b0);
        end
        period(2'h1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("launch test ended");
        syncClear <= 1'b1;
        period(2'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b1);
        syncClear <= 1'b0;
        period(2'h3, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1);
        asyncClear <= 1'b1;
        @(posedge sys_clk);
        #1 note_rx(2'h0);
        note_pad(2'h0);
        @(posedge sys_clk);
        asyncClear <= 1'b0;
        @(posedge sys_clk);
        #1 note_rx(2'h0);
        @(posedge sys_clk);
        asyncPreset <= 1'b1;
        @(posedge sys_clk);
        #1 note_rx(2'h3);
        note_pad(2'h1);
        @(posedge sys_clk);
        asyncPreset <= 1'b0;
        @(posedge sys_clk);
        #1 note_rx(2'h3);
        $display("clear test ended");
        end_of_test();
    end
endmodule // testbench
